// *** bench/hspc_monitor.sv ***
`default_nettype none
// strap and pin reuse checks on top ports
module hspc_monitor #(
	parameter int PORTS = 4 // port count
)
(
	input wire logic core_clk, // clock
	input wire logic arst_n, // reset
	input wire logic port4_overcurrent_n, // oc pin
	input wire logic serial_mode_select_n_out, // mode drive
	input wire logic serial_mode_select_n_oe, // mode enable
	input wire logic full_power_mgmt_n_out, // strap pin drive
	input wire logic full_power_mgmt_n_oe, // strap pin enable
	input wire logic [PORTS-1:0] port_power_req, // requests
	input wire logic ss_status_enable, // status on
	input wire logic ss_suspended, // suspend
	input wire logic ss_connected, // connect
	input wire logic i2c_mode, // eeprom mode
	input wire logic smbus_target_mode, // target mode
	input wire logic power_switching_enabled, // switching
	input wire logic port4_overcurrent, // oc flag
	input wire logic [PORTS-1:0] battery_charge_strap, // charging
	input wire logic [1:0] target_addr_strap, // addr bits
	input wire logic straps_valid, // captured
	input wire logic [PORTS-1:0] downstream_power_switch_ctl, // power pins
	input wire logic [PORTS-1:0] downstream_power_switch_oe // pin enables
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// switching on with straps valid, then straps still valid next cycle
	sequence s_switching;
		straps_valid && power_switching_enabled ##1 straps_valid;
	endsequence
	a_oc_follow: assert property (straps_valid && power_switching_enabled |=>
		port4_overcurrent == !$past(port4_overcurrent_n)) else $error("oc flag wrong");
	a_oc_masked: assert property (!power_switching_enabled |-> !port4_overcurrent)
		else $error("oc flag while disabled");
	a_mode_excl: assert property (i2c_mode != smbus_target_mode)
		else $error("serial modes clash");
	a_addr_zero: assert property (i2c_mode |-> target_addr_strap == 2'h0)
		else $error("addr set in eeprom mode");
	a_straps_hold: assert property (straps_valid && $past(straps_valid) |->
		$stable({i2c_mode, power_switching_enabled, battery_charge_strap, target_addr_strap}))
		else $error("strap changed");
	a_pwr_off: assert property (straps_valid && !power_switching_enabled |->
		downstream_power_switch_oe == '0) else $error("power pin driven");
	a_pwr_drive: assert property (s_switching |-> downstream_power_switch_oe == '1 &&
		(downstream_power_switch_ctl ^ $past(port_power_req)) inside {'0, '1})
		else $error("power pin level wrong");
	a_status_mode: assert property (straps_valid && ss_status_enable |=>
		serial_mode_select_n_oe && serial_mode_select_n_out == $past(ss_suspended))
		else $error("suspend status wrong");
	a_status_up: assert property (straps_valid && ss_status_enable |=>
		full_power_mgmt_n_oe && full_power_mgmt_n_out == $past(ss_connected))
		else $error("connect status wrong");
	a_strap_release: assert property (!straps_valid |-> !serial_mode_select_n_oe &&
		!full_power_mgmt_n_oe && downstream_power_switch_oe == '0)
		else $error("strap pin driven before capture");
endmodule
bind hspc_top hspc_monitor #(.PORTS(PORTS)) u_mon (.*);
`default_nettype wire

// *** bench/hspc_pin_model.sv ***
`default_nettype none
// strap resistors facing the hub pins
module hspc_pin_model
(
	input wire logic mode_strap, // mode resistor
	input wire logic fpm_strap, // power strap resistor
	input wire logic [3:0] batt_strap, // charging resistors
	input wire logic mode_out, // hub drive
	input wire logic mode_oe, // hub enable
	input wire logic fpm_out, // hub drive
	input wire logic fpm_oe, // hub enable
	input wire logic [3:0] pwr_out, // hub drive
	input wire logic [3:0] pwr_oe, // hub enables
	output logic mode_pin, // wire level
	output logic fpm_pin, // wire level
	output logic [3:0] pwr_pin // wire levels
);
	// hub drive wins, else the resistor level
	assign mode_pin = mode_oe ? mode_out : mode_strap;
	// charging straps force switching on
	assign fpm_pin = fpm_oe ? fpm_out : (fpm_strap & ~|batt_strap);
	assign pwr_pin = (pwr_oe & pwr_out) | (~pwr_oe & batt_strap);
endmodule
`default_nettype wire

// *** bench/hspc_top_tb_top.sv ***
`default_nettype none
module hspc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, arst_n = 0, oc_n = 1, pol = 1, bit2 = 0, mode_s = 1, fpm_s = 1;
	logic st_en = 0, susp = 0, conn = 0, mode_out, mode_oe, fpm_out, fpm_oe, mode_pin, fpm_pin;
	logic i2c, smb, pse, oc, valid;
	logic [3:0] batt = 0, req = 0, pin, ctl, ctl_oe, bs;
	logic [1:0] addr;
	int failures = 0, samples_checked = 0;
	always #10 core_clk = ~core_clk;
	hspc_top uut (.core_clk(core_clk), .arst_n(arst_n), .port4_overcurrent_n(oc_n),
		.serial_mode_select_n_in(mode_pin), .serial_mode_select_n_out(mode_out),
		.serial_mode_select_n_oe(mode_oe), .full_power_mgmt_n_in(fpm_pin),
		.full_power_mgmt_n_out(fpm_out), .full_power_mgmt_n_oe(fpm_oe),
		.power_switch_polarity(pol), .target_addr_bit2(bit2), .power_ctl_in(pin),
		.downstream_power_switch_ctl(ctl), .downstream_power_switch_oe(ctl_oe),
		.port_power_req(req), .ss_status_enable(st_en), .ss_suspended(susp),
		.ss_connected(conn), .i2c_mode(i2c), .smbus_target_mode(smb),
		.power_switching_enabled(pse), .port4_overcurrent(oc), .battery_charge_strap(bs),
		.target_addr_strap(addr), .straps_valid(valid));
	hspc_pin_model pm (.mode_strap(mode_s), .fpm_strap(fpm_s), .batt_strap(batt),
		.mode_out(mode_out), .mode_oe(mode_oe), .fpm_out(fpm_out), .fpm_oe(fpm_oe),
		.pwr_out(ctl), .pwr_oe(ctl_oe), .mode_pin(mode_pin), .fpm_pin(fpm_pin), .pwr_pin(pin));
	// verdict and end of run
	task automatic results();
		if (failures == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// one compare
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e)
		begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
			failures++;
		end
	endtask
	// let n edges pass, then settle
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// reset with straps c = {mode, fpm, pol, bit2}, then move the resistors
	task automatic t_capture(input logic [3:0] c);
		logic [7:0] e;
		int k;
		@(posedge core_clk);
		arst_n <= 0; mode_s <= c[3]; fpm_s <= c[2]; pol <= c[1]; bit2 <= c[0];
		batt <= c[2] ? 4'h0 : ~c; req <= 4'h0; st_en <= 0; oc_n <= 1;
		repeat (8) @(posedge core_clk);
		arst_n <= 1;
		k = 0;
		while (k < 10 && valid !== 1'b1)
		begin
			settle(1);
			k++;
		end
		if (valid !== 1'b1)
		begin
			failures++;
			results();
		end
		chk(k[7:0], 8'h02);
		e = {c[3], !c[2], c[2] ? 4'h0 : ~c, c[3] ? 2'h0 : {c[0], c[2]}};
		chk({i2c, pse, bs, addr}, e);
		chk(smb, !c[3]);
		@(posedge core_clk);
		mode_s <= ~c[3]; fpm_s <= ~c[2]; bit2 <= ~c[0]; batt <= c; pol <= ~c[1];
		settle(3);
		chk({i2c, pse, bs, addr}, e);
	endtask
	// power outputs and over-current qualification
	task automatic t_power(input logic [3:0] c);
		@(posedge core_clk);
		req <= 4'h5; oc_n <= 0;
		settle(2);
		chk(ctl_oe, c[2] ? 4'h0 : 4'hF);
		if (!c[2]) chk(ctl, c[1] ? 4'h5 : 4'hA);
		chk(oc, !c[2]);
		@(posedge core_clk);
		oc_n <= 1;
		settle(2);
		chk(oc, 0);
	endtask
	// status reuse of the strap pins
	task automatic t_status();
		@(posedge core_clk);
		st_en <= 1; susp <= 1; conn <= 0;
		settle(2);
		chk({mode_pin, fpm_pin}, 2'h2);
		@(posedge core_clk);
		susp <= 0; conn <= 1;
		settle(2);
		chk({mode_pin, fpm_pin}, 2'h1);
	endtask
	// every combination of the mode, fpm, pol and bit2 straps
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			t_capture(i[3:0]);
			t_power(i[3:0]);
			t_status();
		end
		results();
	end
endmodule
`default_nettype wire

// *** design/hspc_cfg.svh ***
`ifndef HSPC_CFG_SVH
`define HSPC_CFG_SVH
// strap meaning levels
`define HSPC_SERIAL_I2C_LEVEL 1'b1
`define HSPC_FPM_ENABLED_LEVEL 1'b0
`define HSPC_POL_HIGH_LEVEL 1'b1
`define HSPC_OC_ACTIVE_LEVEL 1'b0
// reset values of latched straps
`define HSPC_RST_SERIAL_MODE 1'b1
`define HSPC_RST_FPM_N 1'b1
`define HSPC_RST_POL 1'b0
`define HSPC_RST_BATT 4'h0
`define HSPC_RST_ADDR 2'h0
// port count
`define HSPC_PORTS 4
`endif

// *** design/hspc_pkg.sv ***
`default_nettype none
`include "hspc_cfg.svh"
package hspc_pkg;
	// latched strap set
	typedef struct packed {
		logic i2c_mode;
		logic fpm_enabled;
		logic pol_high;
		logic [`HSPC_PORTS-1:0] batt_charge;
		logic [1:0] target_addr;
	} hspc_straps_s;
	// capture sequencing
	typedef enum logic [1:0] {
		HSPC_IN_RESET,
		HSPC_CAPTURE,
		HSPC_RUN
	} hspc_phase_e;
endpackage
`default_nettype wire

// *** design/hspc_port_drive.sv ***
`default_nettype none
`include "hspc_cfg.svh"
// one downstream power switch output, with polarity and strap phase
module hspc_port_drive
(
	input wire logic core_clk, // clock
	input wire logic arst_n, // async reset
	input wire logic run, // straps captured
	input wire logic pol_high, // active-high drive
	input wire logic fpm_enabled, // power switching on
	input wire logic power_on, // request power
	output logic pin_out, // pin level
	output logic pin_oe // pin enable
);
	logic next_pin_out; // next level
	logic next_pin_oe; // next enable
	// release pin during reset so strap can be read
	always_comb
	begin
		next_pin_oe = run && fpm_enabled;
		if (pol_high == `HSPC_POL_HIGH_LEVEL)
		begin
			next_pin_out = power_on;
		end
		else
		begin
			next_pin_out = ~power_on;
		end
	end
	// register drive
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end
endmodule
`default_nettype wire

// *** design/hspc_top.sv ***
`default_nettype none
`include "hspc_cfg.svh"
module hspc_top #(
	parameter int PORTS = `HSPC_PORTS // downstream port count
)
(
	input wire logic core_clk, // 50 MHz clock
	input wire logic arst_n, // async reset, active low
	input wire logic port4_overcurrent_n, // port 4 over-current, low active
	input wire logic serial_mode_select_n_in, // mode pin level
	output logic serial_mode_select_n_out, // mode pin drive level
	output logic serial_mode_select_n_oe, // mode pin drive enable
	input wire logic full_power_mgmt_n_in, // power strap pin level
	output logic full_power_mgmt_n_out, // power strap pin drive level
	output logic full_power_mgmt_n_oe, // power strap pin drive enable
	input wire logic power_switch_polarity, // polarity strap pin
	input wire logic target_addr_bit2, // grouped strap pin level
	input wire logic [PORTS-1:0] power_ctl_in, // power pins read as straps
	output logic [PORTS-1:0] downstream_power_switch_ctl, // power pin levels
	output logic [PORTS-1:0] downstream_power_switch_oe, // power pin enables
	input wire logic [PORTS-1:0] port_power_req, // hub core power requests
	input wire logic ss_status_enable, // additional-feature status enable
	input wire logic ss_suspended, // upstream SuperSpeed suspended
	input wire logic ss_connected, // upstream on SuperSpeed port
	output logic i2c_mode, // serial pins as EEPROM master
	output logic smbus_target_mode, // serial pins as SMBus target
	output logic power_switching_enabled, // power mgmt strap result
	output logic port4_overcurrent, // qualified port 4 over-current
	output logic [PORTS-1:0] battery_charge_strap, // per-port charging support
	output logic [1:0] target_addr_strap, // SMBus address bits 2:1
	output logic straps_valid // straps captured
);
	// capture sequencing
	hspc_pkg::hspc_phase_e phase; // capture phase
	hspc_pkg::hspc_phase_e next_phase; // next phase

	// strap latch
	hspc_pkg::hspc_straps_s straps; // held strap values
	hspc_pkg::hspc_straps_s next_straps; // next strap values

	// capture done flag
	logic valid; // straps captured
	logic next_valid; // next captured flag

	// over-current qualification
	logic oc_flag; // registered over-current
	logic next_oc_flag; // next over-current

	// mode pin status drive
	logic ss_mode_out; // mode pin drive
	logic next_ss_mode_out; // next mode pin drive
	logic ss_mode_oe; // mode pin enable
	logic next_ss_mode_oe; // next mode pin enable

	// power strap pin status drive
	logic ss_up_out; // power strap pin drive
	logic next_ss_up_out; // next power strap drive
	logic ss_up_oe; // power strap pin enable
	logic next_ss_up_oe; // next power strap enable

	// decoded phase and gated requests
	logic capture; // the single capture cycle
	logic run; // after capture
	logic oc_level; // over-current pin at its event level
	logic [PORTS-1:0] port_on; // power requests gated

	// phase decode
	assign capture = (phase == hspc_pkg::HSPC_CAPTURE);
	assign run = (phase == hspc_pkg::HSPC_RUN);

	// phase: one capture cycle after reset release
	// pins are taken one edge late so the release edge never races them
	always_comb
	begin
		next_phase = phase; // hold by default
		unique case (phase)
			// first edge after release arms the capture
			hspc_pkg::HSPC_IN_RESET: next_phase = hspc_pkg::HSPC_CAPTURE;
			// second edge samples the pins, then run
			hspc_pkg::HSPC_CAPTURE: next_phase = hspc_pkg::HSPC_RUN;
			// stay until the next reset
			hspc_pkg::HSPC_RUN: next_phase = hspc_pkg::HSPC_RUN;
		endcase
	end

	// phase register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase <= hspc_pkg::HSPC_IN_RESET; // wait for release
		end
		else
		begin
			phase <= next_phase; // advance
		end
	end

	// strap capture, only in the capture cycle
	// every shared pin is still released here, so only the resistors show
	always_comb
	begin
		next_straps = straps; // straps hold outside capture
		if (capture)
		begin
			// high on the mode pin selects the EEPROM master
			next_straps.i2c_mode = (serial_mode_select_n_in == `HSPC_SERIAL_I2C_LEVEL);
			// low on the power strap pin enables switching
			next_straps.fpm_enabled = (full_power_mgmt_n_in == `HSPC_FPM_ENABLED_LEVEL);
			// high on the polarity pin selects active-high drive
			next_straps.pol_high = (power_switch_polarity == `HSPC_POL_HIGH_LEVEL);
			// released power pins carry the charging straps
			next_straps.batt_charge = power_ctl_in;
			// address bits only meaningful in SMBus mode
			if (serial_mode_select_n_in == `HSPC_SERIAL_I2C_LEVEL)
			begin
				next_straps.target_addr = `HSPC_RST_ADDR; // unused in EEPROM mode
			end
			else
			begin
				next_straps.target_addr = {target_addr_bit2, full_power_mgmt_n_in};
			end
		end
	end

	// strap register; values hold until the next reset
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			straps.i2c_mode <= `HSPC_RST_SERIAL_MODE; // EEPROM mode until sampled
			straps.fpm_enabled <= ~`HSPC_RST_FPM_N; // switching off until sampled
			straps.pol_high <= `HSPC_RST_POL; // active low until sampled
			straps.batt_charge <= `HSPC_RST_BATT; // no charging until sampled
			straps.target_addr <= `HSPC_RST_ADDR; // address bits clear
		end
		else
		begin
			straps <= next_straps;
		end
	end

	// captured flag, set by the capture cycle
	always_comb
	begin
		next_valid = valid || capture;
	end

	// captured flag register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			valid <= 1'b0; // nothing captured yet
		end
		else
		begin
			valid <= next_valid; // stays set until reset
		end
	end

	// over-current pin at its event level
	assign oc_level = (port4_overcurrent_n == `HSPC_OC_ACTIVE_LEVEL);

	// over-current: pin low means event, ignored when switching off
	// the flag follows the pin level; the switch itself holds the event
	always_comb
	begin
		if (run && straps.fpm_enabled)
		begin
			next_oc_flag = oc_level;
		end
		else
		begin
			next_oc_flag = 1'b0; // no over-current input without switching
		end
	end

	// over-current register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			oc_flag <= 1'b0; // no event in reset
		end
		else
		begin
			oc_flag <= next_oc_flag; // one cycle behind the pin
		end
	end

	// mode pin: suspend status once straps are in
	// drive starts after run, so the strap is never fought during capture
	always_comb
	begin
		if (run && ss_status_enable)
		begin
			next_ss_mode_oe = 1'b1;
			next_ss_mode_out = ss_suspended;
		end
		else
		begin
			next_ss_mode_oe = 1'b0; // released, strap resistor shows
			next_ss_mode_out = 1'b0; // quiet level while released
		end
	end

	// mode pin drive register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ss_mode_out <= 1'b0; // released in reset
			ss_mode_oe <= 1'b0; // strap must be readable
		end
		else
		begin
			ss_mode_out <= next_ss_mode_out; // level
			ss_mode_oe <= next_ss_mode_oe; // enable
		end
	end

	// power strap pin: SuperSpeed connect status once straps are in
	always_comb
	begin
		if (run && ss_status_enable)
		begin
			next_ss_up_oe = 1'b1;
			next_ss_up_out = ss_connected;
		end
		else
		begin
			next_ss_up_oe = 1'b0; // released, strap resistor shows
			next_ss_up_out = 1'b0; // quiet level while released
		end
	end

	// power strap pin drive register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ss_up_out <= 1'b0; // released in reset
			ss_up_oe <= 1'b0; // strap must be readable
		end
		else
		begin
			ss_up_out <= next_ss_up_out; // level
			ss_up_oe <= next_ss_up_oe; // enable
		end
	end

	// power requests reach switches only when switching enabled
	assign port_on = straps.fpm_enabled ? port_power_req : '0;

	// one driver per downstream port
	// polarity is applied after the gate, so an off port sits inactive
	genvar gi;
	generate
		for (gi = 0; gi < PORTS; gi++)
		begin : g_port
			// each output registers level and enable with the latched polarity
			hspc_port_drive u_drive (
				.core_clk(core_clk), // shared clock
				.arst_n(arst_n), // shared reset
				.run(run), // drive only after capture
				.pol_high(straps.pol_high),
				.fpm_enabled(straps.fpm_enabled),
				.power_on(port_on[gi]), // gated request
				.pin_out(downstream_power_switch_ctl[gi]), // pin level
				.pin_oe(downstream_power_switch_oe[gi]) // pin enable
			);
		end
	endgenerate

	// mode pin drive
	assign serial_mode_select_n_out = ss_mode_out;
	assign serial_mode_select_n_oe = ss_mode_oe;
	// power strap pin drive
	assign full_power_mgmt_n_out = ss_up_out;
	assign full_power_mgmt_n_oe = ss_up_oe;
	// serial pins serve the EEPROM in I2C mode
	assign i2c_mode = straps.i2c_mode;
	// serial pins answer the host in SMBus mode
	assign smbus_target_mode = ~straps.i2c_mode;
	// switching and over-current inputs on
	assign power_switching_enabled = straps.fpm_enabled;
	// qualified over-current
	assign port4_overcurrent = oc_flag;
	// per-port charging support
	assign battery_charge_strap = straps.batt_charge;
	// address bits, already zero in I2C mode
	assign target_addr_strap = straps.target_addr;
	// straps captured
	assign straps_valid = valid;
endmodule
`default_nettype wire
